// ---- hw/fod_cfg.svh ----
// Purpose: Object indices, limits and factory values
// Assumes: Included by the dictionary module
// Notes:   Definitions only
`ifndef FOD_CFG_SVH
`define FOD_CFG_SVH

// ----------------------------------------------------------------
// Object indices
// ----------------------------------------------------------------
`define FOD_IDX_RXMAP0     16'h1600
`define FOD_IDX_TXMAP0     16'h1A00
`define FOD_IDX_RXASSIGN   16'h1C12
`define FOD_IDX_TXASSIGN   16'h1C13
`define FOD_IDX_LOSS       16'h6007
`define FOD_IDX_FAULT      16'h603F
`define FOD_IDX_CMD        16'h6040
`define FOD_IDX_PARAM_HI   12'h300

// ----------------------------------------------------------------
// Sub-indices and limits
// ----------------------------------------------------------------
`define FOD_SUB_COUNT      8'h00
`define FOD_SUB_ASSIGN     8'h01
`define FOD_SUB_ENTRY_MAX  8'h08
`define FOD_SUB_PARAM_MAX  8'h64
`define FOD_MAP_MAX_CNT    8'h08
`define FOD_ASSIGN_MAX_CNT 8'h01
`define FOD_PD_MAX_BITS    11'h040

// ----------------------------------------------------------------
// Factory values
// ----------------------------------------------------------------
`define FOD_RST_MAP_CNT    8'h00
`define FOD_RST_ENTRY      32'h00000000
`define FOD_RST_ASSIGN_CNT 8'h01
`define FOD_RST_LOSS       16'h0002
`define FOD_RST_CMD        16'h0000

// ----------------------------------------------------------------
// Connection-loss codes and command word layout
// ----------------------------------------------------------------
`define FOD_LOSS_NONE      16'h0000
`define FOD_LOSS_SOD       16'h0002
`define FOD_LOSS_QSTOP     16'h0003
`define FOD_CMD_MASK       16'h01FF
`define FOD_CMD_FAULT_RST  7

`endif

// ---- hw/fod_pkg.sv ----
// Purpose: Types shared by the object dictionary files
// Assumes: Constants come from fod_cfg.svh
// Notes:   Structs carry request and answer groups
package fod_pkg;

  // SDO request from the protocol engine
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [15:0] index;
    logic [7:0]  sub;
    logic [31:0] wdata;
  } fod_sdo_req_t;

  // SDO answer, ack is a one-cycle pulse
  typedef struct packed {
    logic        ack;
    logic        err;
    logic [31:0] rdata;
  } fod_sdo_rsp_t;

  // Command word arriving in process data
  typedef struct packed {
    logic        valid;
    logic [15:0] word;
  } fod_pd_cmd_t;

  // Access to the drive parameter store
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [3:0]  group;
    logic [6:0]  num;
    logic [15:0] wdata;
  } fod_par_req_t;

  typedef enum logic [0:0] {
    FOD_ST_IDLE = 1'h0,
    FOD_ST_PAR  = 1'h1
  } fod_state_t;

endpackage

// ---- hw/fod_sync3.sv ----
// Purpose: Three-stage synchroniser for the link status pin
// Assumes: Input is asynchronous to i_clk
// Notes:   Level moves only when stages two and three agree
`timescale 1ns/100ps
module fod_sync3 (
  input  wire logic i_clk,
  input  wire logic i_rst_b,
  input  wire logic i_async,
  output logic      o_level
);

  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  logic lvl_reg;

  // First stage feeds only the second
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      s1_reg  <= 1'h0;
      s2_reg  <= 1'h0;
      s3_reg  <= 1'h0;
      lvl_reg <= 1'h0;
    end else begin
      s1_reg <= i_async;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
      if (s2_reg == s3_reg) begin
        lvl_reg <= s3_reg;
      end
    end
  end

  assign o_level = lvl_reg;

endmodule

// ---- hw/fod_map_len.sv ----
// Purpose: Bit length of the enabled entries of a mapping record
// Assumes: Entry bits 7:0 hold the mapped object length in bits
// Notes:   Purely combinational
`timescale 1ns/100ps
module fod_map_len #(
  parameter int N_ENTRY = 8
) (
  input  wire logic [N_ENTRY-1:0][31:0] i_entries,
  input  wire logic [7:0]               i_count,
  output logic [10:0]                   o_bits
);

  logic [10:0] psum [0:N_ENTRY];

  // Running sum, entries beyond the count add nothing
  assign psum[0] = 11'h000;
  for (genvar g = 0; g < N_ENTRY; g++) begin : g_sum
    assign psum[g+1] = psum[g] + ((8'(g) < i_count) ? {3'h0, i_entries[g][7:0]} : 11'h000);
  end

  assign o_bits = psum[N_ENTRY];

endmodule

// ---- hw/fod_object_dictionary.sv ----
// Purpose: Object dictionary of the drive fieldbus slave
// Assumes: One SDO request outstanding; process data on the same clock
// Notes:   Link status pin is synchronised here
`timescale 1ns/100ps
`include "fod_cfg.svh"

// How it works
// - A process-data set never exceeds 64 bits; longer mappings are refused.
// - Transmit record sub-index 0 counts entries: 0 disables, 1 to 8 enables.
// - Four transmit records, eight 32-bit entries each, all cleared at reset.
// - Receive assignment count is 8-bit, 0 or 1, starts at 1.
// - Receive assignment index accepts the four receive record indices only.
// - Transmit assignment count is 8-bit, 0 or 1, starts at 1.
// - Transmit assignment index accepts the four transmit record indices only.
// - Drive parameters are 16-bit and change only through SDO access.
// - Index 300X selects group X; sub-index 1 to 64 hex selects number 0 to 99.
// - Loss option 0 ignores a lost link completely.
// - Loss option 2: switch-on-disabled, warning, stop per quick-stop option.
// - Loss option 3: quick stop, warning, stop per disable-operation option.
// - Command word is 16-bit, resets to 0, bits 9 to 15 reserved.
// - Fault reset acts on the rising edge of command bit 7.
module fod_object_dictionary (
  input  wire logic                 I_CLK,
  input  wire logic                 I_RST_B,
  input  wire fod_pkg::fod_sdo_req_t I_SDO_REQ,
  output fod_pkg::fod_sdo_rsp_t     O_SDO_RSP,
  input  wire fod_pkg::fod_pd_cmd_t I_PD_CMD,
  output fod_pkg::fod_par_req_t     O_PAR_REQ,
  input  wire logic [15:0]          I_PAR_RDATA,
  input  wire logic [15:0]          I_FAULT_CODE,
  input  wire logic                 I_LINK_UP,
  output logic [15:0]               O_CMD_WORD,
  output logic                      O_FAULT_RESET,
  output logic                      O_LINK_LOST_WARNING_DISPLAY,
  output logic                      O_ENTER_SWITCH_ON_DISABLED,
  output logic                      O_ENTER_QUICK_STOP,
  output logic                      O_STOP_BY_DISABLE_OPT,
  output logic [7:0]                O_RX_ASSIGN_COUNT,
  output logic [15:0]               O_RX_ASSIGN_INDEX,
  output logic [7:0]                O_TX_ASSIGN_COUNT,
  output logic [15:0]               O_TX_ASSIGN_INDEX,
  output logic [10:0]               O_TX_PD_BITS
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // True for the four records from base on
  function automatic logic in_range4(input logic [15:0] idx, input logic [15:0] base);
    in_range4 = (idx >= base) && (idx <= base + 16'h0003);
  endfunction

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  fod_pkg::fod_state_t   state_reg;
  fod_pkg::fod_sdo_rsp_t rsp_reg;
  fod_pkg::fod_par_req_t par_reg;
  logic [31:0]           map_mem [0:31];
  logic [7:0]            map_cnt_reg [0:3];
  logic [7:0]            rxa_cnt_reg;
  logic [15:0]           rxa_idx_reg;
  logic [7:0]            txa_cnt_reg;
  logic [15:0]           txa_idx_reg;
  logic [15:0]           loss_reg;
  logic [15:0]           cmd_reg;
  logic                  fr_prev_reg;
  logic                  fr_pulse_reg;
  logic                  link_prev_reg;
  logic                  warn_reg;
  logic                  sod_reg;
  logic                  qs_reg;
  logic                  stop_sel_reg;
  logic [10:0]           pd_bits_reg;

  // ----------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------
  // Requests during a pending parameter access are dropped
  wire        take     = I_SDO_REQ.valid && (state_reg == fod_pkg::FOD_ST_IDLE);
  wire        is_wr    = I_SDO_REQ.write;
  wire [15:0] idx      = I_SDO_REQ.index;
  wire [7:0]  sub      = I_SDO_REQ.sub;
  wire [31:0] wdata    = I_SDO_REQ.wdata;
  wire [7:0]  sub_m1   = sub - 8'h01;
  wire [1:0]  rec      = idx[1:0];
  wire [4:0]  ent_addr = {rec, sub_m1[2:0]};
  wire        sub_zero = (sub == `FOD_SUB_COUNT);
  wire        sub_one  = (sub == `FOD_SUB_ASSIGN);

  // Object hits
  wire hit_tx    = in_range4(idx, `FOD_IDX_TXMAP0);
  wire tx_cnt    = hit_tx && sub_zero;
  wire tx_ent    = hit_tx && (sub >= 8'h01) && (sub <= `FOD_SUB_ENTRY_MAX);
  wire rxa_cnt   = (idx == `FOD_IDX_RXASSIGN) && sub_zero;
  wire rxa_idx   = (idx == `FOD_IDX_RXASSIGN) && sub_one;
  wire txa_cnt   = (idx == `FOD_IDX_TXASSIGN) && sub_zero;
  wire txa_idx   = (idx == `FOD_IDX_TXASSIGN) && sub_one;
  wire hit_loss  = (idx == `FOD_IDX_LOSS) && sub_zero;
  wire hit_fault = (idx == `FOD_IDX_FAULT) && sub_zero;
  wire hit_cmd   = (idx == `FOD_IDX_CMD) && sub_zero;
  wire hit_par   = (idx[15:4] == `FOD_IDX_PARAM_HI) && (sub >= 8'h01)
                   && (sub <= `FOD_SUB_PARAM_MAX);

  // ----------------------------------------------------------------
  // Length of the mapping a count write would enable
  // ----------------------------------------------------------------
  logic [7:0][31:0] cand_ent;
  logic [7:0][31:0] asg_ent;
  logic [10:0]      cand_bits;
  logic [10:0]      asg_bits;
  wire  [1:0]       asg_rec = txa_idx_reg[1:0];

  for (genvar g = 0; g < 8; g++) begin : g_ent
    assign cand_ent[g] = map_mem[{rec, 3'(g)}];
    assign asg_ent[g]  = map_mem[{asg_rec, 3'(g)}];
  end

  fod_map_len #(
    .N_ENTRY (8)
  ) u_cand_len (
    .i_entries (cand_ent),
    .i_count   (wdata[7:0]),
    .o_bits    (cand_bits)
  );

  fod_map_len #(
    .N_ENTRY (8)
  ) u_asg_len (
    .i_entries (asg_ent),
    .i_count   (map_cnt_reg[asg_rec]),
    .o_bits    (asg_bits)
  );

  // ----------------------------------------------------------------
  // Write acceptance
  // ----------------------------------------------------------------
  // Count must be 0..8 and the enabled set must fit in 64 bits
  wire ok_tx_cnt  = tx_cnt && (wdata <= {24'h000000, `FOD_MAP_MAX_CNT})
                    && (cand_bits <= `FOD_PD_MAX_BITS);
  // Entries are frozen while the record is enabled, so a live set cannot grow
  wire ok_tx_ent  = tx_ent && (map_cnt_reg[rec] == `FOD_RST_MAP_CNT);
  wire ok_rxa_cnt = rxa_cnt && (wdata <= {24'h000000, `FOD_ASSIGN_MAX_CNT});
  wire ok_rxa_idx = rxa_idx && (wdata[31:16] == 16'h0000)
                    && in_range4(wdata[15:0], `FOD_IDX_RXMAP0);
  wire ok_txa_cnt = txa_cnt && (wdata <= {24'h000000, `FOD_ASSIGN_MAX_CNT});
  wire ok_txa_idx = txa_idx && (wdata[31:16] == 16'h0000)
                    && in_range4(wdata[15:0], `FOD_IDX_TXMAP0);
  wire loss_val   = (wdata[15:0] == `FOD_LOSS_NONE) || (wdata[15:0] == `FOD_LOSS_SOD)
                    || (wdata[15:0] == `FOD_LOSS_QSTOP);
  wire ok_loss    = hit_loss && loss_val
                    && (wdata[31:16] == {16{wdata[15]}});
  wire ok_cmd     = hit_cmd && (wdata[31:16] == 16'h0000);
  wire wr_ok      = ok_tx_cnt | ok_tx_ent | ok_rxa_cnt | ok_rxa_idx | ok_txa_cnt
                    | ok_txa_idx | ok_loss | ok_cmd;
  wire par_ok     = hit_par && (!is_wr || (wdata[31:16] == 16'h0000));

  // Storage write strobes
  wire wr_go      = take && is_wr;
  wire do_tx_cnt  = wr_go && ok_tx_cnt;
  wire do_tx_ent  = wr_go && ok_tx_ent;
  wire do_cmd_sdo = wr_go && ok_cmd;

  // ----------------------------------------------------------------
  // Read data selection
  // ----------------------------------------------------------------
  wire rd_ok = tx_cnt | tx_ent | rxa_cnt | rxa_idx | txa_cnt | txa_idx
               | hit_loss | hit_fault | hit_cmd;
  wire [31:0] rd_data =
    tx_cnt    ? {24'h000000, map_cnt_reg[rec]} :
    tx_ent    ? map_mem[ent_addr] :
    rxa_cnt   ? {24'h000000, rxa_cnt_reg} :
    rxa_idx   ? {16'h0000, rxa_idx_reg} :
    txa_cnt   ? {24'h000000, txa_cnt_reg} :
    txa_idx   ? {16'h0000, txa_idx_reg} :
    hit_loss  ? {{16{loss_reg[15]}}, loss_reg} :
    hit_fault ? {16'h0000, I_FAULT_CODE} :
    hit_cmd   ? {16'h0000, cmd_reg} : 32'h00000000;

  // ----------------------------------------------------------------
  // SDO answer and parameter window
  // ----------------------------------------------------------------
  // Parameter access answers one cycle later
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      state_reg <= fod_pkg::FOD_ST_IDLE;
      rsp_reg   <= '0;
      par_reg   <= '0;
    end else begin
      rsp_reg.ack   <= 1'h0;
      par_reg.valid <= 1'h0;
      case (state_reg)
        fod_pkg::FOD_ST_IDLE: begin
          if (take && par_ok) begin
            par_reg.valid <= 1'h1;
            par_reg.write <= is_wr;
            par_reg.group <= idx[3:0];
            par_reg.num   <= sub_m1[6:0];
            par_reg.wdata <= wdata[15:0];
            state_reg     <= fod_pkg::FOD_ST_PAR;
          end else if (take) begin
            rsp_reg.ack   <= 1'h1;
            rsp_reg.err   <= is_wr ? !wr_ok : !rd_ok;
            rsp_reg.rdata <= is_wr ? 32'h00000000 : rd_data;
          end
        end
        fod_pkg::FOD_ST_PAR: begin
          rsp_reg.ack   <= 1'h1;
          rsp_reg.err   <= 1'h0;
          rsp_reg.rdata <= par_reg.write ? 32'h00000000 : {16'h0000, I_PAR_RDATA};
          state_reg     <= fod_pkg::FOD_ST_IDLE;
        end
        default: begin
          state_reg <= fod_pkg::FOD_ST_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Transmit mapping records
  // ----------------------------------------------------------------
  // Entries and counts start cleared, mapping disabled
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      for (int i = 0; i < 32; i++) begin
        map_mem[i] <= `FOD_RST_ENTRY;
      end
      for (int r = 0; r < 4; r++) begin
        map_cnt_reg[r] <= `FOD_RST_MAP_CNT;
      end
    end else begin
      if (do_tx_ent) begin
        map_mem[ent_addr] <= wdata;
      end
      if (do_tx_cnt) begin
        map_cnt_reg[rec] <= wdata[7:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // Assignment arrays and loss option
  // ----------------------------------------------------------------
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      rxa_cnt_reg <= `FOD_RST_ASSIGN_CNT;
      rxa_idx_reg <= `FOD_IDX_RXMAP0;
      txa_cnt_reg <= `FOD_RST_ASSIGN_CNT;
      txa_idx_reg <= `FOD_IDX_TXMAP0;
      loss_reg    <= `FOD_RST_LOSS;
    end else if (wr_go) begin
      if (ok_rxa_cnt) rxa_cnt_reg <= wdata[7:0];
      if (ok_rxa_idx) rxa_idx_reg <= wdata[15:0];
      if (ok_txa_cnt) txa_cnt_reg <= wdata[7:0];
      if (ok_txa_idx) txa_idx_reg <= wdata[15:0];
      if (ok_loss)    loss_reg    <= wdata[15:0];
    end
  end

  // Live transmit set length, zero when unassigned
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      pd_bits_reg <= 11'h000;
    end else begin
      pd_bits_reg <= (txa_cnt_reg == 8'h00) ? 11'h000 : asg_bits;
    end
  end

  // ----------------------------------------------------------------
  // Command word
  // ----------------------------------------------------------------
  // SDO write wins over process data in the same cycle; reserved bits stay 0
  wire        cmd_load = do_cmd_sdo || I_PD_CMD.valid;
  wire [15:0] cmd_src  = do_cmd_sdo ? wdata[15:0] : I_PD_CMD.word;
  wire [15:0] cmd_next = cmd_src & `FOD_CMD_MASK;
  wire        fr_now   = cmd_reg[`FOD_CMD_FAULT_RST];

  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      cmd_reg      <= `FOD_RST_CMD;
      fr_prev_reg  <= 1'h0;
      fr_pulse_reg <= 1'h0;
    end else begin
      if (cmd_load) begin
        cmd_reg <= cmd_next;
      end
      fr_prev_reg  <= fr_now;
      fr_pulse_reg <= fr_now && !fr_prev_reg;
    end
  end

  // ----------------------------------------------------------------
  // Connection loss
  // ----------------------------------------------------------------
  logic link_ok;

  fod_sync3 u_link_sync (
    .i_clk   (I_CLK),
    .i_rst_b (I_RST_B),
    .i_async (I_LINK_UP),
    .o_level (link_ok)
  );

  wire link_lost = link_prev_reg && !link_ok;
  wire link_back = !link_prev_reg && link_ok;
  wire opt_sod   = (loss_reg == `FOD_LOSS_SOD);
  wire opt_qs    = (loss_reg == `FOD_LOSS_QSTOP);

  // Option 0 matches neither branch, so nothing happens
  always_ff @(posedge I_CLK or negedge I_RST_B) begin
    if (!I_RST_B) begin
      link_prev_reg <= 1'h0;
      warn_reg      <= 1'h0;
      sod_reg       <= 1'h0;
      qs_reg        <= 1'h0;
      stop_sel_reg  <= 1'h0;
    end else begin
      link_prev_reg <= link_ok;
      sod_reg       <= link_lost && opt_sod;
      qs_reg        <= link_lost && opt_qs;
      if (link_lost && opt_sod) begin
        warn_reg     <= 1'h1;
        stop_sel_reg <= 1'h0;
      end else if (link_lost && opt_qs) begin
        warn_reg     <= 1'h1;
        stop_sel_reg <= 1'h1;
      end else if (link_back) begin
        warn_reg <= 1'h0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign O_SDO_RSP                   = rsp_reg;
  assign O_PAR_REQ                   = par_reg;
  assign O_CMD_WORD                  = cmd_reg;
  assign O_FAULT_RESET               = fr_pulse_reg;
  assign O_LINK_LOST_WARNING_DISPLAY = warn_reg;
  assign O_ENTER_SWITCH_ON_DISABLED  = sod_reg;
  assign O_ENTER_QUICK_STOP          = qs_reg;
  assign O_STOP_BY_DISABLE_OPT       = stop_sel_reg;
  assign O_RX_ASSIGN_COUNT           = rxa_cnt_reg;
  assign O_RX_ASSIGN_INDEX           = rxa_idx_reg;
  assign O_TX_ASSIGN_COUNT           = txa_cnt_reg;
  assign O_TX_ASSIGN_INDEX           = txa_idx_reg;
  assign O_TX_PD_BITS                = pd_bits_reg;

endmodule

// ---- test/fod_od_assertions.sv ----
// Purpose: Port-level checks of the object dictionary
// Assumes: One clock domain, reset active low
// Notes:   Bound to the top module below
`timescale 1ns/100ps
module fod_od_assertions (
  input wire logic                  I_CLK,
  input wire logic                  I_RST_B,
  input wire fod_pkg::fod_sdo_req_t I_SDO_REQ,
  input wire fod_pkg::fod_sdo_rsp_t O_SDO_RSP,
  input wire fod_pkg::fod_pd_cmd_t  I_PD_CMD,
  input wire fod_pkg::fod_par_req_t O_PAR_REQ,
  input wire logic [15:0]           I_PAR_RDATA,
  input wire logic                  I_LINK_UP,
  input wire logic [15:0]           O_CMD_WORD,
  input wire logic                  O_FAULT_RESET,
  input wire logic                  O_LINK_LOST_WARNING_DISPLAY,
  input wire logic                  O_ENTER_SWITCH_ON_DISABLED,
  input wire logic                  O_ENTER_QUICK_STOP,
  input wire logic                  O_STOP_BY_DISABLE_OPT,
  input wire logic [7:0]            O_RX_ASSIGN_COUNT,
  input wire logic [15:0]           O_RX_ASSIGN_INDEX,
  input wire logic [7:0]            O_TX_ASSIGN_COUNT,
  input wire logic [15:0]           O_TX_ASSIGN_INDEX
);
  default clocking cb @(posedge I_CLK);
  endclocking
  default disable iff (!I_RST_B);
  // Requests during a pending parameter access are dropped
  wire par_go = I_SDO_REQ.valid && I_SDO_REQ.index[15:4] == 12'h300 && !O_PAR_REQ.valid
    && I_SDO_REQ.sub != 8'h00 && I_SDO_REQ.sub <= 8'h64
    && (!I_SDO_REQ.write || I_SDO_REQ.wdata[31:16] == 16'h0000);
  sequence s_par_fwd;
    O_PAR_REQ.valid && O_PAR_REQ.group == $past(I_SDO_REQ.index[3:0])
      && O_PAR_REQ.num == $past(I_SDO_REQ.sub[6:0]) - 7'h01
      && O_PAR_REQ.wdata == $past(I_SDO_REQ.wdata[15:0]);
  endsequence
  sequence s_par_ack;
    O_SDO_RSP.ack && !O_SDO_RSP.err;
  endsequence
  a_param_window_map: assert property (par_go |=> s_par_fwd ##1 s_par_ack)
    else $error("parameter decode wrong");
  a_param_read_data: assert property (O_PAR_REQ.valid && !O_PAR_REQ.write
    |=> O_SDO_RSP.rdata == {16'h0000, $past(I_PAR_RDATA)}) else $error("parameter data lost");
  a_ro_write_err: assert property (I_SDO_REQ.valid && I_SDO_REQ.write
    && I_SDO_REQ.index == 16'h603F && !O_PAR_REQ.valid |=> O_SDO_RSP.ack && O_SDO_RSP.err)
    else $error("read-only write accepted");
  a_cmd_reserved_zero: assert property (O_CMD_WORD[15:9] == 7'h00) else $error("reserved bits set");
  a_fault_rst_edge: assert property ($rose(O_CMD_WORD[7]) |=> O_FAULT_RESET ##1 !O_FAULT_RESET)
    else $error("fault reset pulse wrong");
  a_pd_cmd_load: assert property (I_PD_CMD.valid && !I_SDO_REQ.valid
    |=> O_CMD_WORD == ($past(I_PD_CMD.word) & 16'h01FF)) else $error("command not loaded");
  a_assign_index_range: assert property (O_RX_ASSIGN_INDEX[15:2] == 14'h0580
    && O_TX_ASSIGN_INDEX[15:2] == 14'h0680) else $error("assign index range");
  a_assign_count_range: assert property (O_RX_ASSIGN_COUNT <= 8'h01
    && O_TX_ASSIGN_COUNT <= 8'h01) else $error("assign count range");
  a_sod_pulse_state: assert property (O_ENTER_SWITCH_ON_DISABLED
    |-> O_LINK_LOST_WARNING_DISPLAY && !O_STOP_BY_DISABLE_OPT) else $error("loss reaction 2 wrong");
  a_qstop_pulse_state: assert property (O_ENTER_QUICK_STOP
    |-> O_LINK_LOST_WARNING_DISPLAY && O_STOP_BY_DISABLE_OPT) else $error("loss reaction 3 wrong");
  a_warn_needs_action: assert property ($rose(O_LINK_LOST_WARNING_DISPLAY)
    |-> O_ENTER_SWITCH_ON_DISABLED || O_ENTER_QUICK_STOP) else $error("warning without reaction");
  a_warn_clears: assert property (I_LINK_UP [*8] |-> !O_LINK_LOST_WARNING_DISPLAY)
    else $error("warning not cleared");
endmodule

bind fod_object_dictionary fod_od_assertions u_chk (.I_CLK, .I_RST_B, .I_SDO_REQ, .O_SDO_RSP, .I_PD_CMD, .O_PAR_REQ,
  .I_PAR_RDATA, .I_LINK_UP, .O_CMD_WORD, .O_FAULT_RESET, .O_LINK_LOST_WARNING_DISPLAY, .O_STOP_BY_DISABLE_OPT,
  .O_ENTER_SWITCH_ON_DISABLED, .O_ENTER_QUICK_STOP, .O_RX_ASSIGN_COUNT, .O_RX_ASSIGN_INDEX, .O_TX_ASSIGN_COUNT,
  .O_TX_ASSIGN_INDEX);

// ---- test/fod_param_store_model.sv ----
// Purpose: Drive parameter store seen behind the parameter window
// Assumes: Read data is wanted in the request cycle
// Notes:   Data encodes group and number so a wrong decode shows
`timescale 1ns/100ps
module fod_param_store_model (
  input  wire fod_pkg::fod_par_req_t i_par_req,
  output logic [15:0]                o_par_rdata
);
  // Outside a request the bus shows inverted data, never a stale value
  assign o_par_rdata = i_par_req.valid ? {1'b1, i_par_req.group, i_par_req.num, 4'h5}
                                       : ~{1'b1, i_par_req.group, i_par_req.num, 4'h5};
endmodule

// ---- test/fieldbus_object_dictionary_tb.sv ----
// Purpose: Self-checking bench of the object dictionary
// Assumes: Request valid is a one-cycle pulse
// Notes:   Fault code input held at a fixed value
`timescale 1ns/100ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin bad_count++; \
  $display("ERROR %0t mismatch got %h exp %h", $time, a, b); end end
module fieldbus_object_dictionary_tb;
  logic                  I_CLK = 1'b0;
  logic                  I_RST_B = 1'b0;
  logic                  I_LINK_UP = 1'b1;
  logic [15:0]           I_FAULT_CODE = 16'h2310;
  fod_pkg::fod_sdo_req_t I_SDO_REQ = '0;
  fod_pkg::fod_pd_cmd_t  I_PD_CMD = '0;
  fod_pkg::fod_sdo_rsp_t O_SDO_RSP;
  fod_pkg::fod_par_req_t O_PAR_REQ;
  logic [15:0]           I_PAR_RDATA, O_CMD_WORD, O_RX_ASSIGN_INDEX, O_TX_ASSIGN_INDEX;
  logic [7:0]            O_RX_ASSIGN_COUNT, O_TX_ASSIGN_COUNT;
  logic [10:0]           O_TX_PD_BITS;
  logic                  O_FAULT_RESET, O_LINK_LOST_WARNING_DISPLAY, O_ENTER_SWITCH_ON_DISABLED;
  logic                  O_ENTER_QUICK_STOP, O_STOP_BY_DISABLE_OPT, er;
  logic [31:0]           rd;
  logic [31:0]           opts [3] = '{32'h0, 32'h2, 32'h3};
  logic [3:0]            lexp [3] = '{4'h0, 4'h6, 4'hB};
  int                    bad_count = 0;
  int                    checks_done = 0;

  always #4 I_CLK = ~I_CLK;

  fod_object_dictionary uut (.I_CLK, .I_RST_B, .I_SDO_REQ, .O_SDO_RSP, .I_PD_CMD, .O_PAR_REQ, .I_PAR_RDATA,
    .I_FAULT_CODE, .I_LINK_UP, .O_CMD_WORD, .O_FAULT_RESET, .O_LINK_LOST_WARNING_DISPLAY, .O_STOP_BY_DISABLE_OPT,
    .O_ENTER_SWITCH_ON_DISABLED, .O_ENTER_QUICK_STOP, .O_RX_ASSIGN_COUNT, .O_RX_ASSIGN_INDEX, .O_TX_ASSIGN_COUNT,
    .O_TX_ASSIGN_INDEX, .O_TX_PD_BITS);
  fod_param_store_model u_par (.i_par_req(O_PAR_REQ), .o_par_rdata(I_PAR_RDATA));

  task test_done;
    $display("checks %0d errors %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // One SDO access, bounded answer wait
  task sdo(input logic w, input logic [15:0] idx, input logic [7:0] sb, input logic [31:0] wd);
    int n;
    @(posedge I_CLK);
    I_SDO_REQ <= '{1'b1, w, idx, sb, wd};
    @(posedge I_CLK);
    I_SDO_REQ.valid <= 1'b0;
    #1;
    for (n = 0; n < 8 && O_SDO_RSP.ack !== 1'b1; n++) begin
      @(posedge I_CLK);
      #1;
    end
    if (n == 8) begin
      $display("ERROR %0t answer timeout", $time);
      bad_count++;
      test_done();
    end
    er = O_SDO_RSP.err;
    rd = O_SDO_RSP.rdata;
  endtask

  task sw(input logic [15:0] idx, input logic [7:0] sb, input logic [31:0] wd, input logic e);
    sdo(1'b1, idx, sb, wd);
    `CHK(er, e)
  endtask

  task rdx(input logic [15:0] idx, input logic [7:0] sb, input logic [31:0] e);
    sdo(1'b0, idx, sb, 32'h0);
    `CHK({er, rd}, {1'b0, e})
  endtask

  // Process-data command; counts fault reset pulses
  task pd(input logic [15:0] w, output int c);
    @(posedge I_CLK);
    I_PD_CMD <= '{1'b1, w};
    @(posedge I_CLK);
    I_PD_CMD.valid <= 1'b0;
    c = 0;
    repeat (4) begin
      @(posedge I_CLK);
      #1;
      c += int'(O_FAULT_RESET === 1'b1);
    end
  endtask

  task t_reset;
    `CHK({O_RX_ASSIGN_COUNT, O_RX_ASSIGN_INDEX, O_TX_ASSIGN_COUNT, O_TX_ASSIGN_INDEX}, 48'h011600011A00)
    `CHK(O_CMD_WORD, 16'h0000)
    rdx(16'h6007, 8'h00, 32'h00000002);
    for (int i = 0; i < 4; i++) begin
      rdx(16'h1A00 + 16'(i), 8'h00, 32'h0);
      rdx(16'h1A00 + 16'(i), 8'h08, 32'h0);
    end
  endtask

  task t_assign;
    sw(16'h1C12, 8'h00, 32'h2, 1'b1);
    sw(16'h1C12, 8'h01, 32'h1604, 1'b1);
    sw(16'h1C13, 8'h01, 32'h19FF, 1'b1);
    sw(16'h1C12, 8'h00, 32'h0, 1'b0);
    sw(16'h1C13, 8'h01, 32'h1A03, 1'b0);
    `CHK({O_RX_ASSIGN_COUNT, O_TX_ASSIGN_INDEX}, 24'h001A03)
    sw(16'h1C12, 8'h00, 32'h1, 1'b0);
  endtask

  // Entries of 16 and 56 bits overflow, 16 and 48 fit exactly
  task t_map;
    sw(16'h1A03, 8'h01, 32'h60400010, 1'b0);
    sw(16'h1A03, 8'h02, 32'h603F0038, 1'b0);
    sw(16'h1A03, 8'h00, 32'h2, 1'b1);
    sw(16'h1A03, 8'h02, 32'h603F0030, 1'b0);
    sw(16'h1A03, 8'h00, 32'h9, 1'b1);
    sw(16'h1A03, 8'h00, 32'h2, 1'b0);
    sw(16'h1A03, 8'h01, 32'h0, 1'b1);
    @(posedge I_CLK);
    #1;
    `CHK(O_TX_PD_BITS, 11'h040)
    sw(16'h1C13, 8'h00, 32'h0, 1'b0);
    @(posedge I_CLK);
    #1;
    `CHK(O_TX_PD_BITS, 11'h000)
  endtask

  task t_param;
    rdx(16'h3005, 8'h22, 32'h0000AA15);
    sw(16'h3005, 8'h65, 32'h0, 1'b1);
    sw(16'h300F, 8'h01, 32'h1234, 1'b0);
  endtask

  task t_cmd;
    int c;
    sw(16'h6040, 8'h00, 32'h0000FFFF, 1'b0);
    `CHK(O_CMD_WORD, 16'h01FF)
    sw(16'h6040, 8'h00, 32'h00010000, 1'b1);
    sw(16'h603F, 8'h00, 32'h0, 1'b1);
    rdx(16'h603F, 8'h00, 32'h00002310);
    pd(16'h0000, c);
    pd(16'hFE80, c);
    `CHK(O_CMD_WORD, 16'h0080)
    `CHK(c, 1)
    pd(16'hFE80, c);
    `CHK(c, 0)
  endtask

  // Each loss option: drop link, watch, reconnect
  task t_link;
    logic [1:0] p;
    sw(16'h6007, 8'h00, 32'h1, 1'b1);
    for (int i = 0; i < 3; i++) begin
      sw(16'h6007, 8'h00, opts[i], 1'b0);
      @(posedge I_CLK);
      I_LINK_UP <= 1'b0;
      p = 2'b00;
      repeat (12) begin
        @(posedge I_CLK);
        #1;
        p |= {O_ENTER_QUICK_STOP, O_ENTER_SWITCH_ON_DISABLED};
      end
      `CHK({p, O_LINK_LOST_WARNING_DISPLAY, O_STOP_BY_DISABLE_OPT}, lexp[i])
      @(posedge I_CLK);
      I_LINK_UP <= 1'b1;
      repeat (12) @(posedge I_CLK);
      #1;
      `CHK(O_LINK_LOST_WARNING_DISPLAY, 1'b0)
    end
  endtask

  initial begin
    repeat (2) @(posedge I_CLK);
    I_RST_B <= 1'b1;
    #1;
    t_reset();
    t_assign();
    t_map();
    t_param();
    t_cmd();
    t_link();
    test_done();
  end
endmodule
